// ---- flash_wp_pkg.sv ----
// constants, status layout and carrier types for the flash write protect block
package flash_wp_pkg;

    localparam int CLK_PERIOD_NS = 50;
    localparam int SRW_TIME_NS   = 5000;
    localparam int SRW_CYCLES    =
        (SRW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // status word field positions
    localparam int BUSY_BIT     = 0;
    localparam int WEL_BIT      = 1;
    localparam int PROTECT_LSB  = 2;
    localparam int LOCK_LO_BIT  = 7;
    localparam int LOCK_HI_BIT  = 8;
    localparam int QUAD_BIT     = 9;
    localparam int RESERVED_LSB = 10;

    localparam logic [15:0] STATUS_RESET  = 16'h0000;
    localparam logic [2:0]  CS_IDLE_SYNC  = 3'h7;

    // protected span sizes in bytes
    localparam logic [23:0] SPAN_4K  = 24'h001000;
    localparam logic [23:0] SPAN_8K  = 24'h002000;
    localparam logic [23:0] SPAN_16K = 24'h004000;
    localparam logic [23:0] SPAN_32K = 24'h008000;

    localparam logic [7:0] CMD_WRITE_UNLOCK  = 8'h06;
    localparam logic [7:0] CMD_WRITE_LOCK    = 8'h04;
    localparam logic [7:0] CMD_STATUS_RD_LO  = 8'h05;
    localparam logic [7:0] CMD_STATUS_RD_HI  = 8'h35;
    localparam logic [7:0] CMD_STATUS_WRITE  = 8'h01;
    localparam logic [7:0] CMD_PAGE_WRITE    = 8'h02;
    localparam logic [7:0] CMD_SMALL_WIPE    = 8'h20;
    localparam logic [7:0] CMD_LARGE_WIPE_32 = 8'h52;
    localparam logic [7:0] CMD_LARGE_WIPE_64 = 8'hd8;
    localparam logic [7:0] CMD_ARRAY_WIPE_A  = 8'hc7;
    localparam logic [7:0] CMD_ARRAY_WIPE_B  = 8'h60;

    typedef enum logic [1:0] {
        LOCK_SOFT  = 2'b00,
        LOCK_HW    = 2'b01,
        LOCK_POWER = 2'b10,
        LOCK_PERM  = 2'b11
    } lock_mode_e;

    typedef enum logic [1:0] {
        OP_PAGE  = 2'b00,
        OP_SMALL = 2'b01,
        OP_LARGE = 2'b10,
        OP_ARRAY = 2'b11
    } op_kind_e;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_RX   = 2'b01,
        PH_TX   = 2'b10
    } phase_e;

    typedef struct packed {
        logic [5:0] reserved;
        logic       quadLane;
        lock_mode_e lockMode;
        logic [4:0] protectSel;
        logic       writeLatch;
        logic       busy;
    } status_s;

    typedef struct packed {
        op_kind_e    kind;
        logic [23:0] addr;
    } op_req_s;

    typedef struct packed {
        logic [2:0]  sclkSync;
        logic [2:0]  csSync;
        logic [1:0]  siSync;
        logic [1:0]  wpSync;
        logic [1:0]  pauseSync;
        phase_e      phase;
        logic [7:0]  cmd;
        logic [7:0]  rxShift;
        logic [2:0]  bitCnt;
        logic [2:0]  byteCnt;
        logic [23:0] addr;
        logic [7:0]  txShift;
        logic        so;
        logic        soOe;
        status_s     stat;
        logic [7:0]  srwCnt;
        logic        loaded;
        op_req_s     opReq;
        logic        opStart;
        logic        cmdRefused;
        logic        nvWrite;
    } ctrl_state_s;

endpackage : flash_wp_pkg

// ---- flash_write_protect_status.sv ----
// status register and write protection gate of a serial nor flash
`timescale 1ns/1ps
module flash_write_protect_status #(
    parameter int DENSITY_KB = 128
) (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  sclk,
    input  wire logic                  csN,
    input  wire logic                  si,
    input  wire logic                  wpN,
    input  wire logic                  pauseN,
    input  wire logic                  engineBusy,
    input  wire flash_wp_pkg::status_s nvImage,
    output logic                       so,
    output logic                       soOe,
    output flash_wp_pkg::status_s      status,
    output flash_wp_pkg::op_req_s      opReq,
    output logic                       opStart,
    output logic                       cmdRefused,
    output logic                       nvWrite
);
    import flash_wp_pkg::*;

    localparam logic [23:0] ARRAY_BYTES = 24'(DENSITY_KB * 1024);
    localparam logic [23:0] HALF_BYTES  = 24'(DENSITY_KB * 512);

    if (DENSITY_KB != 128 && DENSITY_KB != 64) begin : g_bad_density
        $error("DENSITY_KB must be 128 or 64");
    end
    if (SRW_CYCLES > 255) begin : g_bad_srw
        $error("status write time exceeds counter");
    end

    ctrl_state_s state_q;
    ctrl_state_s state_d;

    // region decode for both densities
    function automatic logic inRegion(input logic [4:0]  bp,
                                      input logic [23:0] rawAddr);
        logic [23:0] a;
        logic [23:0] span;
        logic        hit;
        a    = rawAddr & (ARRAY_BYTES - 24'h000001);
        hit  = 1'b0;
        span = SPAN_32K;
        if (!bp[4]) begin
            if (bp[1:0] == 2'b00) begin
                hit = 1'b0;
            end else if (DENSITY_KB == 64 || bp[1]) begin
                hit = 1'b1;
            end else begin
                hit = bp[3] ? (a < HALF_BYTES) : (a >= HALF_BYTES);
            end
        end else begin
            case (bp[2:0])
                3'b000:  span = 24'h000000;
                3'b001:  span = SPAN_4K;
                3'b010:  span = SPAN_8K;
                3'b011:  span = SPAN_16K;
                3'b111:  span = ARRAY_BYTES;
                default: span = SPAN_32K;
            endcase
            if (span == 24'h000000) begin
                hit = 1'b0;
            end else if (bp[3]) begin
                hit = a < span;
            end else begin
                hit = a >= (ARRAY_BYTES - span);
            end
        end
        return hit;
    endfunction : inRegion
    logic       sclkRise;
    logic       sclkFall;
    logic       csRise;
    logic       paused;
    logic       wpLow;
    logic       busyNow;
    logic       framed;
    logic       lockOk;
    logic [7:0] rxByte;
    logic [7:0] newLo;
    logic [7:0] newHi;
    op_kind_e   kind;
    logic       isOp;
    logic       lenOk;

    always_comb begin
        state_d = state_q;
        // pins cross into mclk through two flops
        state_d.sclkSync  = {state_q.sclkSync[1:0], sclk};
        state_d.csSync    = {state_q.csSync[1:0], csN};
        state_d.siSync    = {state_q.siSync[0], si};
        state_d.wpSync    = {state_q.wpSync[0], wpN};
        state_d.pauseSync = {state_q.pauseSync[0], pauseN};
        state_d.opStart    = 1'b0;
        state_d.cmdRefused = 1'b0;
        state_d.nvWrite    = 1'b0;
        sclkRise = state_q.sclkSync[1] & ~state_q.sclkSync[2];
        sclkFall = ~state_q.sclkSync[1] & state_q.sclkSync[2];
        csRise   = state_q.csSync[1] & ~state_q.csSync[2];
        // spare pins only act as controls while quad is off
        paused   = ~state_q.stat.quadLane & ~state_q.pauseSync[1];
        wpLow    = ~state_q.stat.quadLane & ~state_q.wpSync[1];
        busyNow  = (state_q.srwCnt != 8'h00) | engineBusy;
        framed   = state_q.bitCnt == 3'h0;
        rxByte   = {state_q.rxShift[6:0], state_q.siSync[1]};
        newLo    = state_q.addr[7:0];
        newHi    = 8'h00;
        // a third data byte still shifts addr, so look one byte up
        if (state_q.byteCnt >= 3'h4) begin
            newLo = state_q.addr[23:16];
            newHi = state_q.addr[15:8];
        end else if (state_q.byteCnt == 3'h3) begin
            newLo = state_q.addr[15:8];
            newHi = state_q.addr[7:0];
        end
        case (state_q.stat.lockMode)
            LOCK_SOFT: lockOk = 1'b1;
            LOCK_HW:   lockOk = ~wpLow;
            default:   lockOk = 1'b0;
        endcase
        kind  = OP_PAGE;
        isOp  = 1'b1;
        lenOk = 1'b0;
        case (state_q.cmd)
            CMD_PAGE_WRITE: begin
                kind  = OP_PAGE;
                lenOk = state_q.byteCnt >= 3'h5;
            end
            CMD_SMALL_WIPE: begin
                kind  = OP_SMALL;
                lenOk = state_q.byteCnt == 3'h4;
            end
            CMD_LARGE_WIPE_32, CMD_LARGE_WIPE_64: begin
                kind  = OP_LARGE;
                lenOk = state_q.byteCnt == 3'h4;
            end
            CMD_ARRAY_WIPE_A, CMD_ARRAY_WIPE_B: begin
                kind  = OP_ARRAY;
                lenOk = state_q.byteCnt == 3'h1;
            end
            default: isOp = 1'b0;
        endcase
        if (state_q.srwCnt != 8'h00) begin
            state_d.srwCnt = state_q.srwCnt - 8'h01;
        end
        if (!state_q.loaded) begin
            state_d.loaded              = 1'b1;
            state_d.stat.protectSel     = nvImage.protectSel;
            state_d.stat.quadLane       = nvImage.quadLane;
            state_d.stat.lockMode       = nvImage.lockMode;
            // power lock-down ends with the power cycle
            if (nvImage.lockMode == LOCK_POWER) begin
                state_d.stat.lockMode = LOCK_SOFT;
            end
        end
        if (state_q.csSync[1]) begin
            // deselect resets the serial front end
            state_d.phase   = PH_IDLE;
            state_d.bitCnt  = 3'h0;
            state_d.byteCnt = 3'h0;
            state_d.soOe    = 1'b0;
        end else if (!paused) begin
            if (state_q.phase == PH_IDLE) begin
                state_d.phase = PH_RX;
            end
            if (sclkRise) begin
                state_d.rxShift = rxByte;
                state_d.bitCnt  = state_q.bitCnt + 3'h1;
                if (state_q.bitCnt == 3'h7) begin
                    if (state_q.byteCnt != 3'h7) begin
                        state_d.byteCnt = state_q.byteCnt + 3'h1;
                    end
                    if (state_q.byteCnt == 3'h0) begin
                        state_d.cmd = rxByte;
                        if (rxByte == CMD_STATUS_RD_LO ||
                            rxByte == CMD_STATUS_RD_HI) begin
                            state_d.phase = PH_TX;
                        end
                    end else if (state_q.byteCnt <= 3'h3) begin
                        state_d.addr = {state_q.addr[15:0], rxByte};
                    end
                    // reload each byte so a read streams live status
                    if (state_q.cmd == CMD_STATUS_RD_HI ||
                        (state_q.byteCnt == 3'h0 &&
                         rxByte == CMD_STATUS_RD_HI)) begin
                        state_d.txShift = state_q.stat[15:8];
                    end else begin
                        state_d.txShift = state_q.stat[7:0];
                    end
                end
            end
            if (sclkFall && state_q.phase == PH_TX) begin
                state_d.so      = state_q.txShift[7];
                state_d.soOe    = 1'b1;
                state_d.txShift = {state_q.txShift[6:0], 1'b0};
            end
        end
        if (csRise && state_q.phase == PH_RX && state_q.byteCnt != 3'h0) begin
            if (state_q.cmd == CMD_WRITE_UNLOCK ||
                state_q.cmd == CMD_WRITE_LOCK) begin
                if (!framed || busyNow || state_q.byteCnt != 3'h1) begin
                    state_d.cmdRefused = 1'b1;
                end else begin
                    state_d.stat.writeLatch =
                        state_q.cmd == CMD_WRITE_UNLOCK;
                end
            end else if (state_q.cmd == CMD_STATUS_WRITE) begin
                if (!framed || busyNow || !state_q.stat.writeLatch ||
                    state_q.byteCnt < 3'h2) begin
                    state_d.cmdRefused = 1'b1;
                end else begin
                    state_d.stat.writeLatch = 1'b0;
                    if (!lockOk) begin
                        state_d.cmdRefused = 1'b1;
                    end else begin
                        // new protect bits from the data byte
                        state_d.stat.protectSel =
                            newLo[LOCK_LO_BIT-1:PROTECT_LSB];
                        state_d.stat.lockMode = lock_mode_e'(
                            {state_q.stat.lockMode[1], newLo[LOCK_LO_BIT]});
                        if (state_q.byteCnt >= 3'h3) begin
                            state_d.stat.lockMode = lock_mode_e'(
                                {newHi[LOCK_HI_BIT-8], newLo[LOCK_LO_BIT]});
                            state_d.stat.quadLane = newHi[QUAD_BIT-8];
                        end
                        state_d.srwCnt  = 8'(SRW_CYCLES);
                        state_d.nvWrite = 1'b1;
                    end
                end
            end else if (isOp) begin
                if (!framed || !lenOk || busyNow ||
                    !state_q.stat.writeLatch) begin
                    state_d.cmdRefused = 1'b1;
                end else begin
                    // latch cleared by program and erase
                    state_d.stat.writeLatch = 1'b0;
                    // whole-array erase needs all protect bits clear
                    if (kind == OP_ARRAY &&
                        state_q.stat.protectSel != 5'h00) begin
                        state_d.cmdRefused = 1'b1;
                    end else if (kind != OP_ARRAY &&
                        inRegion(state_q.stat.protectSel,
                                 state_q.addr)) begin
                        state_d.cmdRefused = 1'b1;
                    end else begin
                        state_d.opStart    = 1'b1;
                        state_d.opReq.kind = kind;
                        state_d.opReq.addr = state_q.addr;
                    end
                end
            end
        end
        // busy covers engine work and status write time
        state_d.stat.busy = (state_d.srwCnt != 8'h00) | engineBusy |
                            state_d.opStart;
        state_d.stat.reserved = 6'h00;
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q        <= '0;
            state_q.csSync <= CS_IDLE_SYNC;
        end else begin
            state_q <= state_d;
        end
    end
    // status word straight from the register
    assign status     = state_q.stat;
    assign so         = state_q.so;
    assign soOe       = state_q.soOe;
    assign opReq      = state_q.opReq;
    assign opStart    = state_q.opStart;
    assign cmdRefused = state_q.cmdRefused;
    assign nvWrite    = state_q.nvWrite;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_status_commit;
        state_q.nvWrite;
    endsequence
    sequence s_busy_hold;
        state_q.stat.busy [*8];
    endsequence
    property p_busy_after_write;
        s_status_commit |-> s_busy_hold;
    endproperty
    a_busy_after_write: assert property (p_busy_after_write)
        else $error("busy dropped during status write");
    property p_op_needs_latch;
        state_q.opStart |-> $past(state_q.stat.writeLatch);
    endproperty
    a_op_needs_latch: assert property (p_op_needs_latch)
        else $error("operation started without write latch");
    property p_latch_cleared;
        (state_q.opStart || state_q.nvWrite) |-> !state_q.stat.writeLatch;
    endproperty
    a_latch_cleared: assert property (p_latch_cleared)
        else $error("write latch not cleared after write command");
    property p_array_wipe;
        state_q.opStart && state_q.opReq.kind == OP_ARRAY
            |-> $past(state_q.stat.protectSel) == 5'h00;
    endproperty
    a_array_wipe: assert property (p_array_wipe)
        else $error("array erase while protect bits set");
    property p_region;
        state_q.opStart && state_q.opReq.kind != OP_ARRAY
            |-> !inRegion($past(state_q.stat.protectSel), state_q.opReq.addr);
    endproperty
    a_region: assert property (p_region)
        else $error("operation started in protected region");
    property p_lock_gate;
        s_status_commit |-> $past(state_q.stat.lockMode) == LOCK_SOFT ||
            ($past(state_q.stat.lockMode) == LOCK_HW && $past(~wpLow));
    endproperty
    a_lock_gate: assert property (p_lock_gate)
        else $error("status write accepted while locked");
    property p_protect_source;
        $past(state_q.loaded) && $changed(state_q.stat.protectSel)
            |-> state_q.nvWrite;
    endproperty
    a_protect_source: assert property (p_protect_source)
        else $error("protect bits changed without status write");
    property p_power_unlock;
        $rose(state_q.loaded) |-> state_q.stat.lockMode != LOCK_POWER;
    endproperty
    a_power_unlock: assert property (p_power_unlock)
        else $error("power lock-down survived power cycle");
    property p_reserved;
        state_q.loaded |=> state_q.stat.reserved == 6'h00;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved status bits nonzero");
endmodule : flash_write_protect_status

// ---- spi_host_model.sv ----
// serial host model that drives the link pins of the flash status block
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic mclk,
    output logic      sclk,
    output logic      csN,
    output logic      si,
    input  wire logic so,
    input  wire logic soOe
);
    import flash_wp_pkg::*;

    // 4 mclk high and 5 mclk low per bit (HALF plus the data setup cycle) gives the 450 ns link clock
    localparam int HALF = 4;

    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        si   = 1'b0;
    end

    // mode 0 frame, msb first; clock stands low outside frames
    task automatic xfer(input logic [7:0] bytes[$], output logic [7:0] rx);
        logic [7:0] b;
        rx = 8'h00;
        @(posedge mclk) csN <= 1'b0;
        foreach (bytes[k]) begin
            b = bytes[k];
            for (int i = 7; i >= 0; i--) begin
                @(posedge mclk) si <= b[i];
                repeat (HALF) @(posedge mclk);
                sclk <= 1'b1;
                repeat (HALF) @(posedge mclk);
                // so from the previous fall has settled long ago
                rx = {rx[6:0], (soOe === 1'b1) ? so : ~rx[0]};
                sclk <= 1'b0;
            end
        end
        repeat (HALF) @(posedge mclk);
        csN <= 1'b1;
        // released data line must not look held
        si  <= ~si;
        // deselect time, so the next frame cannot follow one cycle later
        repeat (HALF) @(posedge mclk);
    endtask : xfer

endmodule : spi_host_model

// ---- tb_top.sv ----
// self-checking bench for the flash write protect status block
`timescale 1ns/1ps
module tb_top;
    import flash_wp_pkg::*;

    logic        mclk, rst, sclk, csN, si, wpN, pauseN, engineBusy;
    logic        so, soOe, opStart, cmdRefused, nvWrite;
    status_s     nvImage, status;
    op_req_s     opReq, lastReq;
    int          errTotal = 0, nCompared = 0, cycles = 0, engCnt = 0;
    int          nGrant = 0, nRefuse = 0, nStore = 0;

    // sel, grant, kind, command, address
    localparam logic [39:0] TAB [17] = '{
        {5'b00001, 1'b0, OP_SMALL, CMD_SMALL_WIPE, 24'h010000},
        {5'b00001, 1'b1, OP_PAGE, CMD_PAGE_WRITE, 24'h00ffff},
        {5'b01001, 1'b0, OP_LARGE, CMD_LARGE_WIPE_32, 24'h00ffff},
        {5'b01001, 1'b1, OP_LARGE, CMD_LARGE_WIPE_64, 24'h010000},
        {5'b00010, 1'b0, OP_SMALL, CMD_SMALL_WIPE, 24'h000000},
        {5'b10001, 1'b0, OP_PAGE, CMD_PAGE_WRITE, 24'h01f000},
        {5'b10001, 1'b1, OP_SMALL, CMD_SMALL_WIPE, 24'h01efff},
        {5'b11011, 1'b0, OP_SMALL, CMD_SMALL_WIPE, 24'h003fff},
        {5'b11011, 1'b1, OP_PAGE, CMD_PAGE_WRITE, 24'h004000},
        {5'b10101, 1'b0, OP_LARGE, CMD_LARGE_WIPE_64, 24'h018000},
        {5'b10101, 1'b1, OP_SMALL, CMD_SMALL_WIPE, 24'h017fff},
        {5'b10111, 1'b0, OP_SMALL, CMD_SMALL_WIPE, 24'h000000},
        {5'b10000, 1'b1, OP_SMALL, CMD_SMALL_WIPE, 24'h01ffff},
        {5'b11000, 1'b1, OP_PAGE, CMD_PAGE_WRITE, 24'h000000},
        {5'b00000, 1'b1, OP_ARRAY, CMD_ARRAY_WIPE_A, 24'h000000},
        {5'b10000, 1'b0, OP_ARRAY, CMD_ARRAY_WIPE_B, 24'h000000},
        {5'b00000, 1'b1, OP_ARRAY, CMD_ARRAY_WIPE_B, 24'h000000}};

    flash_write_protect_status #(.DENSITY_KB(128))
        u_flash_write_protect_status (
        .mclk(mclk), .rst(rst), .sclk(sclk), .csN(csN), .si(si), .wpN(wpN),
        .pauseN(pauseN), .engineBusy(engineBusy), .nvImage(nvImage),
        .so(so), .soOe(soOe), .status(status), .opReq(opReq),
        .opStart(opStart), .cmdRefused(cmdRefused), .nvWrite(nvWrite));

    spi_host_model u_spi_host_model (
        .mclk(mclk), .sclk(sclk), .csN(csN), .si(si), .so(so), .soOe(soOe));

    always #25 mclk = ~mclk;

    // pulse counters, engine stand-in and hang guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (opStart === 1'b1) begin
            nGrant  <= nGrant + 1;
            lastReq <= opReq;
        end
        if (cmdRefused === 1'b1) nRefuse <= nRefuse + 1;
        if (nvWrite === 1'b1) nStore <= nStore + 1;
        engCnt     <= (opStart === 1'b1) ? 20 : (engCnt > 0 ? engCnt - 1 : 0);
        engineBusy <= (opStart === 1'b1) || (engCnt > 1);
        if (cycles == 30000) begin
            errTotal++;
            completeRun();
        end
    end

    task automatic completeRun();
        if (errTotal == 0 && nCompared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : completeRun

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        nCompared++;
        if (seen !== exp) begin
            errTotal++;
            $display("MISMATCH %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle

    task automatic powerUp(input status_s img);
        @(posedge mclk) begin
            nvImage <= img;
            rst     <= 1'b1;
        end
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        settle(4);
    endtask : powerUp

    // one frame, then grant, refusal and store pulse counts
    task automatic run(input logic [7:0] b[$], input int g, input int r,
                       input int w);
        int         g0, r0, w0;
        logic [7:0] rx;
        g0 = nGrant;
        r0 = nRefuse;
        w0 = nStore;
        u_spi_host_model.xfer(b, rx);
        settle(8);
        check(nGrant - g0, g, "grant pulses");
        check(nRefuse - r0, r, "refuse pulses");
        check(nStore - w0, w, "store pulses");
    endtask : run

    task automatic swr(input logic [7:0] lo, input logic [7:0] hi,
                       input int w);
        run({CMD_WRITE_UNLOCK}, 0, 0, 0);
        run({CMD_STATUS_WRITE, lo, hi}, 0, 1 - w, w);
        settle(105);
    endtask : swr

    task automatic tPower();
        logic [7:0] rx;
        powerUp(status_s'({6'h3f, 1'b0, LOCK_POWER, 5'b01001, 2'b11}));
        check(status, 16'h0024, "status after power-up");
        u_spi_host_model.xfer({CMD_STATUS_RD_LO, 8'h00}, rx);
        check(rx, 8'h24, "low status byte");
        u_spi_host_model.xfer({CMD_STATUS_RD_HI, 8'h00}, rx);
        check(rx, 8'h00, "high status byte");
    endtask : tPower

    task automatic tLatch();
        powerUp('0);
        run({CMD_STATUS_WRITE, 8'h0c, 8'h00}, 0, 1, 0);
        run({CMD_SMALL_WIPE, 8'h00, 8'h00, 8'h00}, 0, 1, 0);
        run({CMD_WRITE_UNLOCK}, 0, 0, 0);
        check(status.writeLatch, 1'b1, "latch set");
        run({CMD_WRITE_LOCK}, 0, 0, 0);
        check(status.writeLatch, 1'b0, "latch cleared");
    endtask : tLatch

    task automatic tStatusWrite();
        run({CMD_WRITE_UNLOCK}, 0, 0, 0);
        run({CMD_STATUS_WRITE, 8'h0c, 8'hfc, 8'hff}, 0, 0, 1);
        check(status, 16'h000d, "status during store");
        settle(100);
        check(status.busy, 1'b0, "busy after store");
    endtask : tStatusWrite

    task automatic tLock();
        powerUp('0);
        @(posedge mclk) wpN <= 1'b0;
        swr(8'h84, 8'h00, 1);
        swr(8'h80, 8'h00, 0);
        check(status.protectSel, 5'b00001, "protect kept");
        @(posedge mclk) wpN <= 1'b1;
        swr(8'h00, 8'h01, 1);
        swr(8'h00, 8'h00, 0);
        check(status.lockMode, LOCK_POWER, "lock kept");
        powerUp(status_s'(16'h0180));
        swr(8'h00, 8'h00, 0);
    endtask : tLock

    task automatic tQuad();
        powerUp(status_s'(16'h0280));
        @(posedge mclk) begin
            wpN    <= 1'b0;
            pauseN <= 1'b0;
        end
        // spare pins ignored while quad lanes on
        swr(8'h80, 8'h02, 1);
        check(status.quadLane, 1'b1, "quad kept");
        powerUp('0);
        run({CMD_WRITE_UNLOCK}, 0, 0, 0);
        check(status.writeLatch, 1'b0, "paused frame ignored");
        @(posedge mclk) begin
            wpN    <= 1'b1;
            pauseN <= 1'b1;
        end
    endtask : tQuad

    task automatic tProtect();
        logic [39:0] e;
        logic [7:0]  q[$];
        foreach (TAB[k]) begin
            e = TAB[k];
            powerUp(status_s'({9'h000, e[39:35], 2'b00}));
            run({CMD_WRITE_UNLOCK}, 0, 0, 0);
            if (e[31:24] == CMD_PAGE_WRITE) q = {e[31:24], e[23:16], e[15:8],
                                                 e[7:0], 8'h5a};
            else if (e[33:32] == OP_ARRAY) q = {e[31:24]};
            else q = {e[31:24], e[23:16], e[15:8], e[7:0]};
            run(q, int'(e[34]), int'(!e[34]), 0);
            check(status.writeLatch, 1'b0, "latch after op");
            if (e[34]) begin
                check(status.busy, 1'b1, "busy with engine");
                check(lastReq.kind, e[33:32], "op kind");
                if (e[33:32] != OP_ARRAY)
                    check(lastReq.addr, e[23:0], "op addr");
            end
            settle(30);
        end
    endtask : tProtect

    initial begin
        mclk       = 1'b0;
        rst        = 1'b1;
        wpN        = 1'b1;
        pauseN     = 1'b1;
        nvImage    = '0;
        tPower();
        tLatch();
        tStatusWrite();
        tLock();
        tQuad();
        tProtect();
        completeRun();
    end

endmodule : tb_top
